// ==== src/dre_params.svh ====
// constants for the dma request and enable control block
`ifndef DRE_PARAMS_SVH
`define DRE_PARAMS_SVH
// ----------------------------------------------------------------
// sizes
// ----------------------------------------------------------------
`define DRE_NCH 4
`define DRE_NEXT 2
`define DRE_NPER 7
`define DRE_AW 32
`define DRE_CW 32
`define DRE_PAW 12
// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define DRE_OFF_OPR 12'h040
`define DRE_RIX_SAR 2'h0
`define DRE_RIX_DAR 2'h1
`define DRE_RIX_TCR 2'h2
`define DRE_RIX_CHANNEL_CONTROL_REG 2'h3
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define DRE_CC_CE 0
`define DRE_CC_TE 1
`define DRE_CC_IE 2
`define DRE_CC_TS_LO 4
`define DRE_CC_TS_HI 6
`define DRE_CC_RS_LO 8
`define DRE_CC_RS_HI 11
`define DRE_CC_DS 12
`define DRE_OR_ME 0
`define DRE_OR_NMI 1
`define DRE_OR_AE 2
// ----------------------------------------------------------------
// codes, reset values, timing
// ----------------------------------------------------------------
`define DRE_RS_EXT_DUAL 4'h0
`define DRE_RS_EXT_M2D 4'h2
`define DRE_RS_EXT_D2M 4'h3
`define DRE_RS_AUTO 4'h4
`define DRE_RS_PER_BAD 3'h7
`define DRE_TS_BYTE 3'h0
`define DRE_TS_WORD 3'h1
`define DRE_TS_LONG 3'h2
`define DRE_TS_QUAD 3'h3
`define DRE_TS_BLK 3'h4
`define DRE_SZ_BYTE 32'h0000_0001
`define DRE_SZ_WORD 32'h0000_0002
`define DRE_SZ_LONG 32'h0000_0004
`define DRE_SZ_QUAD 32'h0000_0008
`define DRE_SZ_BLK 32'h0000_0020
`define DRE_CNT_RST 32'h0000_0000
`define DRE_CNT_ONE 32'h0000_0001
`define DRE_PIN_IDLE 1'b1
`define DRE_PREADY 1'b1
`define DRE_REARM_CYC 3'h4
`define DRE_REARM_ZERO 3'h0
`define DRE_REARM_ONE 3'h1
`endif

// ==== src/dre_pkg.sv ====
// types shared by the dma request and enable control block
`include "dre_params.svh"
package dre_pkg;
  typedef enum logic [1:0] {
    DRE_IDLE = 2'b01,
    DRE_BUSY = 2'b10
  } dre_state_e;
  typedef struct packed {
    logic [`DRE_PAW-1:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } dre_apb_req_s;
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } dre_apb_rsp_s;
  typedef struct packed {
    logic [`DRE_AW-1:0] src;
    logic [`DRE_AW-1:0] dst;
    logic [2:0] size;
    logic [1:0] chan;
    logic single;
    logic to_device;
  } dre_xfer_s;
endpackage

// ==== src/dre_tcount.sv ====
// per-channel transfer count register with decrement
`timescale 1ns/1ps
`include "dre_params.svh"
module dre_tcount (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic load,
  input wire logic [`DRE_CW-1:0] load_val,
  input wire logic dec,
  output logic [`DRE_CW-1:0] count,
  output logic last
);
  import dre_pkg::*;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= `DRE_CNT_RST;
    end else if (dec) begin
      count <= count - `DRE_CNT_ONE;
    end else if (load) begin
      count <= load_val;
    end
  end
  assign last = (count == `DRE_CNT_ONE);
endmodule

// ==== src/dre_req_sense.sv ====
// external request pin synchroniser, level or falling edge sensing
`timescale 1ns/1ps
`include "dre_params.svh"
module dre_req_sense (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ext_request_n,
  input wire logic sense_edge,
  input wire logic accept,
  input wire logic cancel,
  input wire logic consume,
  output logic pending
);
  import dre_pkg::*;
  logic sync1;
  logic sync2;
  logic prev;
  logic held;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= `DRE_PIN_IDLE;
      sync2 <= `DRE_PIN_IDLE;
      prev <= `DRE_PIN_IDLE;
    end else begin
      sync1 <= ext_request_n;
      sync2 <= sync1;
      prev <= sync2;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      held <= 1'b0;
    end else if (cancel || !sense_edge) begin
      held <= 1'b0;
    end else if (accept && prev && !sync2) begin
      held <= 1'b1;
    end else if (consume) begin
      held <= 1'b0;
    end
  end
  assign pending = sense_edge ? (held && !cancel) : (accept && !sync2);
endmodule

// ==== src/dre_ctrl.sv ====
// dma channel request acceptance, enable gating, sequencing and end logic
// Functional notes
// - transfer needs both enables, no flags set
// - one unit per accepted request, sized
// - auto-request starts once enables are set
// - count decrements by one per unit
// - count zero ends channel, irq if enabled
// - nmi or address error suspends transfer
// - clearing either enable suspends transfer
// - address error always raises its irq
// - disabled request waits until enabled
// - four-bit field selects request mode
// - sense select: low level or falling edge
// - edge request held while channel disabled
// - external codes set address mode, direction
// - external requests ignored under flags, standby
// - held request dropped on nmi, error
// - requester need not be source or destination
// - end flag only on full count completion
// - nmi always sets flag, read-then-zero clear
//
// The APB slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "dre_params.svh"
module dre_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire dre_pkg::dre_apb_req_s apb_req,
  output dre_pkg::dre_apb_rsp_s apb_rsp,
  input wire logic [`DRE_NEXT-1:0] ext_request_n,
  output logic [`DRE_NEXT-1:0] ext_acknowledge,
  input wire logic [`DRE_NPER-1:0] periph_req,
  output logic [`DRE_NPER-1:0] periph_ack,
  input wire logic nmi_event,
  input wire logic standby,
  output logic xfer_valid,
  output dre_pkg::dre_xfer_s xfer,
  input wire logic xfer_done,
  input wire logic xfer_addr_error,
  output logic [`DRE_NCH-1:0] transfer_end_irq,
  output logic address_error_irq
);
  import dre_pkg::*;
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [`DRE_AW-1:0] source_addr_reg [`DRE_NCH];
  logic [`DRE_AW-1:0] dest_addr_reg [`DRE_NCH];
  logic [`DRE_CW-1:0] count [`DRE_NCH];
  logic [`DRE_NCH-1:0] last;
  logic [`DRE_NCH-1:0] ce;
  logic [`DRE_NCH-1:0] te;
  logic [`DRE_NCH-1:0] ie;
  logic [`DRE_NCH-1:0] ds;
  logic [`DRE_NCH-1:0] te_arm;
  logic [2:0] ts [`DRE_NCH];
  logic [3:0] rs [`DRE_NCH];
  logic me;
  logic nmi_flag;
  logic ae;
  logic nmi_arm;
  logic ae_arm;
  logic [31:0] prdata;
  logic pslverr;
  dre_state_e state;
  dre_state_e next_state;
  logic [1:0] cur;
  logic [1:0] pick;
  logic [2:0] rearm;
  dre_xfer_s xfer_q;
  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  logic [`DRE_PAW-1:0] a;
  logic [1:0] ch_sel;
  logic [1:0] rix;
  logic is_opr;
  logic mapped;
  logic access;
  logic wr;
  logic rd;
  logic [31:0] rd_val;
  assign a = apb_req.paddr;
  assign ch_sel = a[5:4];
  assign rix = a[3:2];
  assign is_opr = (a == `DRE_OFF_OPR);
  assign mapped = ((a[`DRE_PAW-1:6] == '0) || is_opr) && (a[1:0] == 2'h0);
  assign access = apb_req.psel && apb_req.penable;
  assign wr = access && apb_req.pwrite && mapped;
  assign rd = access && !apb_req.pwrite && mapped;
  always_comb begin
    rd_val = 32'h0000_0000;
    if (is_opr) begin
      rd_val[`DRE_OR_ME] = me;
      rd_val[`DRE_OR_NMI] = nmi_flag;
      rd_val[`DRE_OR_AE] = ae;
    end else begin
      case (rix)
        `DRE_RIX_SAR: rd_val = source_addr_reg[ch_sel];
        `DRE_RIX_DAR: rd_val = dest_addr_reg[ch_sel];
        `DRE_RIX_TCR: rd_val = count[ch_sel];
        default: begin
          rd_val[`DRE_CC_CE] = ce[ch_sel];
          rd_val[`DRE_CC_TE] = te[ch_sel];
          rd_val[`DRE_CC_IE] = ie[ch_sel];
          rd_val[`DRE_CC_TS_HI:`DRE_CC_TS_LO] = ts[ch_sel];
          rd_val[`DRE_CC_RS_HI:`DRE_CC_RS_LO] = rs[ch_sel];
          rd_val[`DRE_CC_DS] = ds[ch_sel];
        end
      endcase
    end
  end
  // read data captured in the setup cycle, zero wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (apb_req.psel && !apb_req.penable) begin
      prdata <= mapped ? rd_val : 32'h0000_0000;
      pslverr <= !mapped;
    end
  end
  assign apb_rsp = '{prdata: prdata, pready: `DRE_PREADY, pslverr: pslverr};
  // ----------------------------------------------------------------
  // request modes and enables
  // ----------------------------------------------------------------
  logic [`DRE_NCH-1:0] en;
  logic [`DRE_NCH-1:0] is_ext;
  logic [`DRE_NCH-1:0] is_auto;
  logic [`DRE_NCH-1:0] is_per;
  logic [`DRE_NCH-1:0] ext_pend;
  logic [`DRE_NCH-1:0] req;
  logic [`DRE_NCH-1:0] go;
  logic done;
  logic done_ok;
  logic start;
  always_comb begin
    for (int c = 0; c < `DRE_NCH; c++) begin
      en[c] = ce[c] && me && !te[c] && !nmi_flag && !ae;
      is_ext[c] = (rs[c] == `DRE_RS_EXT_DUAL) || (rs[c] == `DRE_RS_EXT_M2D)
                  || (rs[c] == `DRE_RS_EXT_D2M);
      is_auto[c] = (rs[c] == `DRE_RS_AUTO);
      is_per[c] = rs[c][3] && (rs[c][2:0] != `DRE_RS_PER_BAD);
      // auto and peripheral requesters may drive any channel; external pin n drives only channel n, for channels 0 and 1
      req[c] = is_auto[c] || (is_ext[c] && ext_pend[c])
               || (is_per[c] && periph_req[rs[c][2:0]]);
      go[c] = en[c] && req[c];
    end
  end
  genvar g;
  generate
    for (g = 0; g < `DRE_NCH; g++) begin : gen_sense
      if (g < `DRE_NEXT) begin : gen_pin
        // idle line is high, reset value of the synchroniser
        dre_req_sense u_sense (
          .pclk(pclk),
          .presetn(presetn),
          .ext_request_n(ext_request_n[g]),
          .sense_edge(ds[g]),
          .accept(is_ext[g] && !te[g] && !nmi_flag && !ae && !standby),
          .cancel(nmi_flag || ae),
          .consume(done && (cur == g)),
          .pending(ext_pend[g])
        );
      end else begin : gen_nopin
        assign ext_pend[g] = 1'b0;
      end
    end
  endgenerate
  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb begin
    pick = 2'h0;
    for (int c = `DRE_NCH - 1; c >= 0; c--) begin
      if (go[c]) begin
        pick = c[1:0];
      end
    end
  end
  assign done = (state == DRE_BUSY) && xfer_done;
  assign done_ok = done && !xfer_addr_error;
  assign start = (state == DRE_IDLE) && (go != '0) && (rearm == `DRE_REARM_ZERO);
  always_comb begin
    next_state = state;
    case (state)
      DRE_IDLE: begin
        if (start) begin
          next_state = DRE_BUSY;
        end
      end
      // a started unit always runs to its end
      DRE_BUSY: begin
        if (xfer_done) begin
          next_state = DRE_IDLE;
        end
      end
      default: next_state = DRE_IDLE;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= DRE_IDLE;
      cur <= 2'h0;
    end else begin
      state <= next_state;
      if (start) begin
        cur <= pick;
      end
    end
  end
  // gap after each unit lets a level request fall after acknowledge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rearm <= `DRE_REARM_ZERO;
    end else if (done) begin
      rearm <= `DRE_REARM_CYC;
    end else if (rearm != `DRE_REARM_ZERO) begin
      rearm <= rearm - `DRE_REARM_ONE;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xfer_q <= '0;
    end else if (start) begin
      xfer_q.src <= source_addr_reg[pick];
      xfer_q.dst <= dest_addr_reg[pick];
      xfer_q.size <= ts[pick];
      xfer_q.chan <= pick;
      xfer_q.single <= (rs[pick] == `DRE_RS_EXT_M2D) || (rs[pick] == `DRE_RS_EXT_D2M);
      xfer_q.to_device <= (rs[pick] == `DRE_RS_EXT_M2D);
    end
  end
  assign xfer_valid = (state == DRE_BUSY);
  assign xfer = xfer_q;
  // ----------------------------------------------------------------
  // address advance
  // ----------------------------------------------------------------
  logic [`DRE_AW-1:0] step;
  always_comb begin
    case (xfer_q.size)
      `DRE_TS_BYTE: step = `DRE_SZ_BYTE;
      `DRE_TS_WORD: step = `DRE_SZ_WORD;
      `DRE_TS_LONG: step = `DRE_SZ_LONG;
      `DRE_TS_QUAD: step = `DRE_SZ_QUAD;
      `DRE_TS_BLK: step = `DRE_SZ_BLK;
      default: step = `DRE_SZ_LONG;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int c = 0; c < `DRE_NCH; c++) begin
        source_addr_reg[c] <= 32'h0000_0000;
        dest_addr_reg[c] <= 32'h0000_0000;
      end
    end else begin
      for (int c = 0; c < `DRE_NCH; c++) begin
        if (done_ok && (cur == c[1:0])) begin
          if (!xfer_q.single || xfer_q.to_device) begin
            source_addr_reg[c] <= source_addr_reg[c] + step;
          end
          if (!xfer_q.single || !xfer_q.to_device) begin
            dest_addr_reg[c] <= dest_addr_reg[c] + step;
          end
        end else if (wr && !is_opr && (ch_sel == c[1:0])) begin
          if (rix == `DRE_RIX_SAR) begin
            source_addr_reg[c] <= apb_req.pwdata;
          end
          if (rix == `DRE_RIX_DAR) begin
            dest_addr_reg[c] <= apb_req.pwdata;
          end
        end
      end
    end
  end
  // ----------------------------------------------------------------
  // transfer counters
  // ----------------------------------------------------------------
  generate
    for (g = 0; g < `DRE_NCH; g++) begin : gen_cnt
      dre_tcount u_cnt (
        .pclk(pclk),
        .presetn(presetn),
        .load(wr && !is_opr && (ch_sel == g) && (rix == `DRE_RIX_TCR)),
        .load_val(apb_req.pwdata),
        .dec(done_ok && (cur == g)),
        .count(count[g]),
        .last(last[g])
      );
    end
  endgenerate
  // ----------------------------------------------------------------
  // channel control and end flags
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ce <= '0;
      ie <= '0;
      ds <= '0;
      for (int c = 0; c < `DRE_NCH; c++) begin
        ts[c] <= `DRE_TS_BYTE;
        rs[c] <= `DRE_RS_EXT_DUAL;
      end
    end else if (wr && !is_opr && (rix == `DRE_RIX_CHANNEL_CONTROL_REG)) begin
      ce[ch_sel] <= apb_req.pwdata[`DRE_CC_CE];
      ie[ch_sel] <= apb_req.pwdata[`DRE_CC_IE];
      ds[ch_sel] <= apb_req.pwdata[`DRE_CC_DS];
      ts[ch_sel] <= apb_req.pwdata[`DRE_CC_TS_HI:`DRE_CC_TS_LO];
      rs[ch_sel] <= apb_req.pwdata[`DRE_CC_RS_HI:`DRE_CC_RS_LO];
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      te <= '0;
      te_arm <= '0;
    end else begin
      for (int c = 0; c < `DRE_NCH; c++) begin
        if (done_ok && (cur == c[1:0]) && last[c]) begin
          te[c] <= 1'b1;
        end else if (wr && !is_opr && (rix == `DRE_RIX_CHANNEL_CONTROL_REG) && (ch_sel == c[1:0])
                     && te_arm[c] && !apb_req.pwdata[`DRE_CC_TE]) begin
          te[c] <= 1'b0;
        end
        if (rd && !is_opr && (rix == `DRE_RIX_CHANNEL_CONTROL_REG) && (ch_sel == c[1:0])
            && prdata[`DRE_CC_TE]) begin
          te_arm[c] <= 1'b1;
        end else if (wr && !is_opr && (rix == `DRE_RIX_CHANNEL_CONTROL_REG) && (ch_sel == c[1:0])) begin
          te_arm[c] <= 1'b0;
        end
      end
    end
  end
  // ----------------------------------------------------------------
  // operation register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      me <= 1'b0;
    end else if (wr && is_opr) begin
      me <= apb_req.pwdata[`DRE_OR_ME];
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nmi_flag <= 1'b0;
      nmi_arm <= 1'b0;
    end else begin
      if (nmi_event) begin
        nmi_flag <= 1'b1;
      end else if (wr && is_opr && nmi_arm && !apb_req.pwdata[`DRE_OR_NMI]) begin
        nmi_flag <= 1'b0;
      end
      if (rd && is_opr && prdata[`DRE_OR_NMI]) begin
        nmi_arm <= 1'b1;
      end else if (wr && is_opr) begin
        nmi_arm <= 1'b0;
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ae <= 1'b0;
      ae_arm <= 1'b0;
    end else begin
      if (done && xfer_addr_error) begin
        ae <= 1'b1;
      end else if (wr && is_opr && ae_arm && !apb_req.pwdata[`DRE_OR_AE]) begin
        ae <= 1'b0;
      end
      if (rd && is_opr && prdata[`DRE_OR_AE]) begin
        ae_arm <= 1'b1;
      end else if (wr && is_opr) begin
        ae_arm <= 1'b0;
      end
    end
  end
  // ----------------------------------------------------------------
  // acknowledges and interrupt requests
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_acknowledge <= '0;
      periph_ack <= '0;
    end else begin
      for (int c = 0; c < `DRE_NEXT; c++) begin
        ext_acknowledge[c] <= done && (cur == c[1:0]) && is_ext[c];
      end
      for (int k = 0; k < `DRE_NPER; k++) begin
        periph_ack[k] <= done && is_per[cur] && (rs[cur][2:0] == k[2:0]);
      end
    end
  end
  assign transfer_end_irq = te & ie;
  assign address_error_irq = ae;
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_start_gated: assert property (
    @(posedge pclk) disable iff (!presetn) start |-> (ce[pick] && me && !te[pick] && !nmi_flag && !ae)
  ) else $error("unit started on a channel that is not enabled");
  a_flags_block: assert property (
    @(posedge pclk) disable iff (!presetn) (nmi_flag || ae) |-> !start
  ) else $error("unit started while nmi or address error flag set");
  a_count_decr: assert property (
    @(posedge pclk) disable iff (!presetn) done_ok |=> (count[cur] == $past(count[cur]) - `DRE_CNT_ONE)
  ) else $error("transfer count not decremented by one");
  a_end_flag_set: assert property (
    @(posedge pclk) disable iff (!presetn) (done_ok && last[cur]) |=> te[cur] ##0 transfer_end_irq[cur] == ie[cur]
  ) else $error("end flag not set on final unit");
  a_err_no_end: assert property (
    @(posedge pclk) disable iff (!presetn) (done && xfer_addr_error && !te[cur]) |=> !te[cur] && ae
  ) else $error("address error set end flag or missed error flag");
  a_err_irq: assert property (
    @(posedge pclk) disable iff (!presetn) (done && xfer_addr_error) |=> address_error_irq
  ) else $error("address error irq not raised");
  a_unit_runs: assert property (
    @(posedge pclk) disable iff (!presetn) (xfer_valid && !xfer_done) |=> xfer_valid && $stable(xfer)
  ) else $error("unit in progress abandoned or changed");
  a_nmi_flag: assert property (
    @(posedge pclk) disable iff (!presetn) nmi_event |=> nmi_flag [*2]
  ) else $error("nmi flag not set and held");
  a_held_drop: assert property (
    @(posedge pclk) disable iff (!presetn) (nmi_flag || ae) |-> (ext_pend[0] == 1'b0) && !ext_pend[1]
  ) else $error("held external request survived nmi or error");
  a_auto_go: assert property (
    @(posedge pclk) disable iff (!presetn) (state == DRE_IDLE && is_auto[0] && en[0] && rearm == `DRE_REARM_ZERO)
      |=> (state == DRE_BUSY)
  ) else $error("auto-request did not start");
endmodule

// ==== sim/dre_far_model.sv ====
// far side model: bus target and external requester
`timescale 1ns/1ps
module dre_far_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic xfer_valid,
  output logic xfer_done,
  output logic xfer_addr_error,
  input wire logic [1:0] ext_acknowledge,
  output logic [1:0] ext_request_n,
  input wire logic slow,
  input wire logic fail,
  input wire logic req0,
  output int units
);
  logic [2:0] gap;
  // ----------------------------------------
  // unit completion, prompt or slow
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xfer_done <= 1'b0;
      xfer_addr_error <= 1'b0;
      gap <= 3'h0;
      units <= 0;
    end else if (xfer_valid && !xfer_done && gap >= {slow, 2'b00}) begin
      xfer_done <= 1'b1;
      xfer_addr_error <= fail;
      gap <= 3'h0;
      units <= units + (fail ? 0 : 1);
    end else begin
      xfer_done <= 1'b0;
      xfer_addr_error <= 1'b0;
      gap <= xfer_valid ? gap + 3'h1 : 3'h0;
    end
  end
  // ----------------------------------------
  // request pin, held low until acknowledged
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_request_n <= 2'b11;
    end else if (ext_acknowledge[0]) begin
      ext_request_n[0] <= 1'b1;
    end else if (req0) begin
      ext_request_n[0] <= 1'b0;
    end
  end
endmodule

// ==== sim/dre_ctrl_tb.sv ====
// self-checking bench for the dma request and enable control block
`timescale 1ns/1ps
`include "dre_params.svh"
module dre_ctrl_tb;
  import dre_pkg::*;
  typedef struct packed {
    logic [11:0] a;
    logic [31:0] d;
    logic [31:0] q;
    logic e;
  } dre_row_s;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  dre_apb_req_s req = '0;
  dre_apb_rsp_s rsp;
  logic [1:0] ext_request_n;
  logic [1:0] ext_acknowledge;
  logic nmi_event = 1'b0;
  logic standby = 1'b0;
  logic [6:0] pq = 7'h00;
  logic [6:0] periph_ack;
  logic [6:0] pack_seen = 7'h00;
  logic xfer_valid;
  dre_xfer_s xfer;
  dre_xfer_s last_x = '0;
  logic xfer_done;
  logic xfer_addr_error;
  logic [3:0] transfer_end_irq;
  logic address_error_irq;
  logic slow = 1'b0;
  logic fail = 1'b0;
  logic req0 = 1'b0;
  int units;
  int failures = 0;
  int total_checks = 0;
  int n;
  logic [31:0] rd;
  logic er;
  dre_row_s rows [5] = '{
    '{12'h008, 32'h0000_0003, 32'h0000_0003, 1'b0},
    '{12'h00C, 32'h0000_1422, 32'h0000_1420, 1'b0},
    '{12'h040, 32'h0000_0006, 32'h0000_0000, 1'b0},
    '{12'h044, 32'h0000_0001, 32'h0000_0000, 1'b1},
    '{12'h01C, 32'h0000_0230, 32'h0000_0230, 1'b0}
  };
  always #4 pclk = ~pclk;
  always @(posedge pclk) begin
    pack_seen <= pack_seen | periph_ack;
    if (xfer_valid) begin
      last_x <= xfer;
    end
  end
  dre_ctrl i_dre_ctrl (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
    .ext_request_n(ext_request_n), .ext_acknowledge(ext_acknowledge), .periph_req(pq),
    .periph_ack(periph_ack), .nmi_event(nmi_event), .standby(standby), .xfer_valid(xfer_valid),
    .xfer(xfer), .xfer_done(xfer_done), .xfer_addr_error(xfer_addr_error),
    .transfer_end_irq(transfer_end_irq), .address_error_irq(address_error_irq));
  dre_far_model i_dre_far_model (.pclk(pclk), .presetn(presetn), .xfer_valid(xfer_valid),
    .xfer_done(xfer_done), .xfer_addr_error(xfer_addr_error),
    .ext_acknowledge(ext_acknowledge), .ext_request_n(ext_request_n), .slow(slow),
    .fail(fail), .req0(req0), .units(units));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic stop_test();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bound(input int k);
    if (k >= 400) begin
      failures++;
      stop_test();
    end
  endtask
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int k;
    @(posedge pclk);
    req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
    @(posedge pclk);
    req.penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (rsp.pready !== 1'b1 && k < 400);
    bound(k);
    rd = rsp.prdata;
    er = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(12'h040, 1'b0, 32'h0);
    chk(rd, 32'h0);
    foreach (rows[i]) begin
      apb(rows[i].a, 1'b1, rows[i].d);
      apb(rows[i].a, 1'b0, 32'h0);
      chk(rd, rows[i].q);
      chk({31'h0, er}, {31'h0, rows[i].e});
    end
    apb(12'h00C, 1'b1, 32'h0000_0425);
    repeat (8) @(posedge pclk);
    chk(units, 0);
    apb(12'h040, 1'b1, 32'h0000_0001);
    for (n = 0; n < 400 && transfer_end_irq[0] !== 1'b1; n++) @(posedge pclk);
    bound(n);
    chk(units, 3);
    chk({29'h0, last_x.size}, 32'h2);
    apb(12'h008, 1'b0, 32'h0);
    chk(rd, 32'h0);
    apb(12'h00C, 1'b0, 32'h0);
    chk(rd, 32'h0000_0427);
    apb(12'h00C, 1'b1, 32'h0000_0424);
    apb(12'h00C, 1'b0, 32'h0);
    chk({28'h0, transfer_end_irq}, 32'h0);
    fail <= 1'b1;
    apb(12'h018, 1'b1, 32'h5);
    apb(12'h01C, 1'b1, 32'h0000_0401);
    for (n = 0; n < 400 && address_error_irq !== 1'b1; n++) @(posedge pclk);
    bound(n);
    repeat (8) @(posedge pclk);
    chk({31'h0, xfer_valid}, 32'h0);
    apb(12'h018, 1'b0, 32'h0);
    chk(rd, 32'h5);
    apb(12'h01C, 1'b1, 32'h0);
    fail <= 1'b0;
    apb(12'h040, 1'b0, 32'h0);
    chk(rd, 32'h5);
    apb(12'h040, 1'b1, 32'h1);
    apb(12'h040, 1'b0, 32'h0);
    chk(rd, 32'h1);
    slow <= 1'b1;
    apb(12'h008, 1'b1, 32'h1);
    apb(12'h00C, 1'b1, 32'h0000_1200);
    req0 <= 1'b1;
    @(posedge pclk);
    req0 <= 1'b0;
    repeat (8) @(posedge pclk);
    chk(units, 3);
    apb(12'h00C, 1'b1, 32'h0000_1201);
    for (n = 0; n < 400 && units != 4; n++) @(posedge pclk);
    bound(n);
    apb(12'h00C, 1'b0, 32'h0);
    chk(rd, 32'h0000_1203);
    chk({30'h0, last_x.single, last_x.to_device}, 32'h3);
    chk({30'h0, ext_request_n}, 32'h3);
    nmi_event <= 1'b1;
    @(posedge pclk);
    nmi_event <= 1'b0;
    apb(12'h040, 1'b0, 32'h0);
    chk(rd, 32'h3);
    apb(12'h040, 1'b1, 32'h1);
    apb(12'h040, 1'b0, 32'h0);
    chk(rd, 32'h1);
    standby <= 1'b1;
    req0 <= 1'b1;
    apb(12'h00C, 1'b1, 32'h0000_0201);
    repeat (8) @(posedge pclk);
    chk(units, 4);
    standby <= 1'b0;
    for (n = 0; n < 400 && units != 5; n++) @(posedge pclk);
    bound(n);
    req0 <= 1'b0;
    repeat (8) @(posedge pclk);
    chk(units, 5);
    apb(12'h028, 1'b1, 32'h2);
    pq <= 7'h02;
    apb(12'h02C, 1'b1, 32'h0000_0901);
    for (n = 0; n < 400 && units != 7; n++) @(posedge pclk);
    bound(n);
    pq <= 7'h00;
    repeat (8) @(posedge pclk);
    chk(units, 7);
    chk({25'h0, pack_seen}, 32'h2);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(12'h02C, 1'b0, 32'h0);
    chk(rd, 32'h0);
    apb(12'h040, 1'b0, 32'h0);
    chk(rd, 32'h0);
    stop_test();
  end
endmodule
